// ==== hdl/pmrs_defs.svh ====
// Offsets, field positions, reset values and timing counts of the supervisor
`ifndef PMRS_DEFS_SVH
`define PMRS_DEFS_SVH

`define PMRS_CLK_MHZ 100
`define PMRS_RST_MIN_NS 100
`define PMRS_RST_CYC ((`PMRS_RST_MIN_NS * `PMRS_CLK_MHZ + 999) / 1000)
`define PMRS_WAKE_NS 125000
`define PMRS_WAKE_CYC ((`PMRS_WAKE_NS * `PMRS_CLK_MHZ) / 1000)
`define PMRS_TW_DIV_LAST 7'h63

`define PMRS_OFF_MODE 8'h00
`define PMRS_OFF_ACT_TPL 8'h04
`define PMRS_OFF_ALT_TPL 8'h08
`define PMRS_OFF_RST_CTRL 8'h0c
`define PMRS_OFF_RST_CAUSE 8'h10
`define PMRS_OFF_WDT_CTRL 8'h14
`define PMRS_OFF_WDT_LOAD 8'h18
`define PMRS_OFF_LVI_CTRL 8'h1c
`define PMRS_OFF_LVI_STAT 8'h20
`define PMRS_OFF_TW_PERIOD 8'h24

`define PMRS_RSTC_SOFTWARE_RESET_REQUEST 0
`define PMRS_RSTC_SOFTWARE_RESET_REQUEST_DIS 1
`define PMRS_WDTC_EN 0
`define PMRS_WDTC_KICK 1
`define PMRS_LVIC_DCODE 3:0
`define PMRS_LVIC_ACODE 7:4
`define PMRS_LVIC_IRQ_EN 10:8
`define PMRS_LVIC_LVD_RST 11

`define PMRS_CAUSE_POR 0
`define PMRS_CAUSE_EXTERNAL_RESET_PIN 1
`define PMRS_CAUSE_SOFTWARE_RESET_REQUEST 2
`define PMRS_CAUSE_WDT 3
`define PMRS_CAUSE_LVD 4

`define PMRS_TRIP_BASE_MV 2450
`define PMRS_TRIP_STEP_MV 250
`define PMRS_ANALOG_HIGH_VOLTAGE_IRQ_TRIP_MV 5750
`define PMRS_TRIP_CODE_MAX 4'hc

`define PMRS_TPL_RST 8'hff
`define PMRS_WDT_LOAD_RST 24'h0f4240
`define PMRS_TW_PERIOD_RST 16'h0000

`endif

// ==== hdl/pmrs_pkg.sv ====
// Types shared by the power mode and reset supervisor
`include "pmrs_defs.svh"
package pmrs_pkg;

    typedef enum logic [2:0] {
        PMRS_ACTIVE = 3'b000,
        PMRS_ALT = 3'b001,
        PMRS_SLEEP = 3'b010,
        PMRS_HIB = 3'b011,
        PMRS_WAKING = 3'b100
    } pmrs_mode_t;

    typedef struct packed {
        pmrs_mode_t mode;
        logic [7:0] act_tpl;
        logic [7:0] alt_tpl;
        logic software_reset_request_dis;
        logic [4:0] cause;
        logic wdt_en;
        logic [23:0] wdt_load;
        logic [23:0] wdt_cnt;
        logic [15:0] tw_period;
        logic [15:0] tw_cnt;
        logic [6:0] tw_div;
        logic [11:0] lvi_ctrl;
        logic [2:0] lvi_flag;
        logic [13:0] wake_cnt;
        logic [3:0] rst_cnt;
        logic por_done;
        logic [31:0] rdata;
    } pmrs_state_t;

    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] sync;
    } pmrs_sync_state_t;

endpackage

// ==== hdl/pmrs_sync.sv ====
// Two-stage synchroniser for the pin and comparator inputs
`timescale 1ns/1ps
`default_nettype none
module pmrs_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Asynchronous inputs and their synchronised copies
    input wire logic [4:0] async_in,
    output logic [4:0] sync_out
);
    import pmrs_pkg::*;

    pmrs_sync_state_t s;
    pmrs_sync_state_t next_s;

    // First stage feeds only the second stage
    always_comb begin
        next_s = s;
        next_s.meta = async_in;
        next_s.sync = s.meta;
    end

    // Reset value zero: the reset pin reads as asserted until it has crossed
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.sync;
endmodule
`default_nettype wire

// ==== hdl/pmrs_supervisor.sv ====
// Power mode sequencer and system reset supervisor
// How it works
// - Alternate active powers only the subsystems its own template enables
// - Sleep powers down processor, timewheel keeps running, wakes on timewheel or reset
// - Sleep wakeup waits a 125 us settle count before active
// - Hibernate keeps configuration, holds output pins and pin interrupt setup
// - Only the external reset pin ends hibernate
// - Every wakeup returns the global mode to active
// - Low external reset pin holds reset, handled like power-on reset
// - External reset pin works in sleep and hibernate
// - Power-on reset pulse lasts at least 100 ns, longer until supply stable
// - System reset reinitialises processor and all peripherals
// - Reset cause register names latest source, cleared by power-on reset
// - Low-voltage trips from 2.45 V in 250 mV steps, lowest is detect level
// - High-voltage trip is fixed at 5.75 V
// - Monitors can raise processor interrupts on out-of-range supply
// - Monitors off until power-on reset ends and in low-power modes
// - Lowest low-voltage interrupt may fire right after sleep wakeup
// - Software reset bit write acts as a power-on reset
// - Separate disable bit makes software reset writes ineffective
// - Watchdog not restarted before timeout causes system reset
// - Power-on reset clears watchdog enable, once set it stays locked
// - Watchdog counts only in active modes, never in sleep or hibernate
// - Every wakeup re-enables the processor whatever the template says
// - Global mode defaults to active after boot
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_defs.svh"
module pmrs_supervisor #(
    parameter int unsigned WAKE_CYCLES = `PMRS_WAKE_CYC
) (
    // Clock and power-on reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Pins and supply monitors
    input wire logic external_reset_pin_n,
    input wire logic digital_supply_ok,
    input wire logic digital_low_voltage_cmp,
    input wire logic analog_low_voltage_cmp,
    input wire logic analog_high_voltage_cmp,
    // Reset and power control
    output logic sys_rst_n,
    output logic initial_power_on_reset_en,
    output logic cpu_pwr_en,
    output logic [7:0] subsys_pwr_en,
    output logic io_hold,
    output logic timewheel_run,
    output pmrs_pkg::pmrs_mode_t power_mode,
    // Voltage monitor control and interrupts
    output logic mon_en,
    output logic [3:0] digital_low_voltage_irq_trip_code,
    output logic [3:0] analog_low_voltage_irq_trip_code,
    output logic digital_low_voltage_irq,
    output logic analog_low_voltage_irq,
    output logic analog_high_voltage_irq
);
    import pmrs_pkg::*;

    pmrs_state_t s;
    pmrs_state_t next_s;
    logic [4:0] syn;
    logic external_reset_pin_s;
    logic supply_ok_s;
    logic [2:0] cmp_s;
    logic tick;
    logic tw_hit;
    logic run_mode;
    logic mon_on;
    logic software_reset_request_fire;
    logic wdt_fire;
    logic lvd_fire;
    logic [4:0] rst_src;
    logic [2:0] flag_set;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    pmrs_sync u_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .async_in({analog_high_voltage_cmp, analog_low_voltage_cmp,
                   digital_low_voltage_cmp, digital_supply_ok, external_reset_pin_n}),
        .sync_out(syn)
    );
    assign external_reset_pin_s = syn[0];
    assign supply_ok_s = syn[1];
    assign cmp_s = syn[4:2];

    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0;
        run_mode = (s.mode == PMRS_ACTIVE) || (s.mode == PMRS_ALT);
        mon_on = s.por_done && run_mode;
        // Timewheel ticks every microsecond and keeps going in sleep
        tick = (s.tw_div == `PMRS_TW_DIV_LAST);
        next_s.tw_div = tick ? 7'h00 : s.tw_div + 7'h01;
        tw_hit = 1'b0;
        if (tick && s.mode != PMRS_HIB) begin
            if (s.tw_cnt >= s.tw_period) begin
                next_s.tw_cnt = 16'h0000;
                tw_hit = (s.tw_period != 16'h0000);
            end else begin
                next_s.tw_cnt = s.tw_cnt + 16'h0001;
            end
        end
        // Stretch of reset; power-on also waits for the stable supply
        if (s.rst_cnt != 4'h0) begin
            next_s.rst_cnt = s.rst_cnt - 4'h1;
        end
        if (!s.por_done && s.rst_cnt == 4'h0 && supply_ok_s) begin
            next_s.por_done = 1'b1;
        end
        // Pin low before power-on ends only stretches it, so the cause stays power-on
        if (!external_reset_pin_s && !s.por_done) begin
            next_s.rst_cnt = 4'(`PMRS_RST_CYC);
        end
        // Register reads, answered one cycle later
        if (reg_rd) begin
            case (1'b1)
                hit(reg_addr, `PMRS_OFF_MODE): next_s.rdata = {29'h0, s.mode};
                hit(reg_addr, `PMRS_OFF_ACT_TPL): next_s.rdata = {24'h0, s.act_tpl};
                hit(reg_addr, `PMRS_OFF_ALT_TPL): next_s.rdata = {24'h0, s.alt_tpl};
                hit(reg_addr, `PMRS_OFF_RST_CTRL): next_s.rdata = {30'h0, s.software_reset_request_dis, 1'b0};
                hit(reg_addr, `PMRS_OFF_RST_CAUSE): next_s.rdata = {27'h0, s.cause};
                hit(reg_addr, `PMRS_OFF_WDT_CTRL): next_s.rdata = {31'h0, s.wdt_en};
                hit(reg_addr, `PMRS_OFF_WDT_LOAD): next_s.rdata = {8'h0, s.wdt_load};
                hit(reg_addr, `PMRS_OFF_LVI_CTRL): next_s.rdata = {20'h0, s.lvi_ctrl};
                hit(reg_addr, `PMRS_OFF_LVI_STAT): next_s.rdata = {29'h0, s.lvi_flag};
                hit(reg_addr, `PMRS_OFF_TW_PERIOD): next_s.rdata = {16'h0, s.tw_period};
                default: next_s.rdata = 32'h0;
            endcase
        end
        // Register writes
        software_reset_request_fire = 1'b0;
        if (reg_wr) begin
            if (hit(reg_addr, `PMRS_OFF_MODE) && run_mode) begin
                case (reg_wdata[2:0])
                    3'h0: next_s.mode = PMRS_ACTIVE;
                    3'h1: next_s.mode = PMRS_ALT;
                    3'h2: next_s.mode = PMRS_SLEEP;
                    3'h3: next_s.mode = PMRS_HIB;
                    default: next_s.mode = s.mode;
                endcase
            end
            if (hit(reg_addr, `PMRS_OFF_ACT_TPL)) begin
                next_s.act_tpl = reg_wdata[7:0];
            end
            if (hit(reg_addr, `PMRS_OFF_ALT_TPL)) begin
                next_s.alt_tpl = reg_wdata[7:0];
            end
            if (hit(reg_addr, `PMRS_OFF_RST_CTRL)) begin
                next_s.software_reset_request_dis = reg_wdata[`PMRS_RSTC_SOFTWARE_RESET_REQUEST_DIS];
                // Disable is taken from the stored bit, so one write cannot lift and fire
                // Only the pin may end hibernate, so low-power modes ignore the trigger
                software_reset_request_fire = reg_wdata[`PMRS_RSTC_SOFTWARE_RESET_REQUEST] && !s.software_reset_request_dis && run_mode;
            end
            if (hit(reg_addr, `PMRS_OFF_WDT_CTRL)) begin
                if (reg_wdata[`PMRS_WDTC_EN] && !s.wdt_en) begin
                    next_s.wdt_en = 1'b1;
                    next_s.wdt_cnt = s.wdt_load;
                end
                if (reg_wdata[`PMRS_WDTC_KICK]) begin
                    next_s.wdt_cnt = s.wdt_load;
                end
            end
            if (hit(reg_addr, `PMRS_OFF_WDT_LOAD)) begin
                next_s.wdt_load = reg_wdata[23:0];
            end
            if (hit(reg_addr, `PMRS_OFF_LVI_CTRL)) begin
                next_s.lvi_ctrl = reg_wdata[11:0];
                // Codes above the top step saturate there
                if (reg_wdata[3:0] > `PMRS_TRIP_CODE_MAX) begin
                    next_s.lvi_ctrl[`PMRS_LVIC_DCODE] = `PMRS_TRIP_CODE_MAX;
                end
                if (reg_wdata[7:4] > `PMRS_TRIP_CODE_MAX) begin
                    next_s.lvi_ctrl[`PMRS_LVIC_ACODE] = `PMRS_TRIP_CODE_MAX;
                end
            end
            if (hit(reg_addr, `PMRS_OFF_TW_PERIOD)) begin
                next_s.tw_period = reg_wdata[15:0];
            end
        end
        // Sticky monitor flags, set wins over a clearing write
        flag_set = cmp_s & s.lvi_ctrl[`PMRS_LVIC_IRQ_EN] & {3{mon_on}};
        next_s.lvi_flag = s.lvi_flag | flag_set;
        if (reg_wr && hit(reg_addr, `PMRS_OFF_LVI_STAT)) begin
            next_s.lvi_flag = (s.lvi_flag & ~reg_wdata[2:0]) | flag_set;
        end
        // Watchdog stands still outside the active modes
        wdt_fire = 1'b0;
        if (s.wdt_en && run_mode && s.por_done) begin
            if (s.wdt_cnt == 24'h0) begin
                wdt_fire = 1'b1;
            end else if (!(reg_wr && hit(reg_addr, `PMRS_OFF_WDT_CTRL))) begin
                next_s.wdt_cnt = s.wdt_cnt - 24'h1;
            end
        end
        // Lowest trip setting doubles as the low-voltage detect reset
        lvd_fire = mon_on && s.lvi_ctrl[`PMRS_LVIC_LVD_RST] && cmp_s[0]
                   && (s.lvi_ctrl[`PMRS_LVIC_DCODE] == 4'h0);
        // Sleep wakeup with settle time
        if (s.mode == PMRS_SLEEP && tw_hit) begin
            next_s.mode = PMRS_WAKING;
            next_s.wake_cnt = 14'(WAKE_CYCLES - 1);
        end
        if (s.mode == PMRS_WAKING) begin
            if (s.wake_cnt == 14'h0) begin
                next_s.mode = PMRS_ACTIVE;
                next_s.act_tpl[0] = 1'b1;
            end else begin
                next_s.wake_cnt = s.wake_cnt - 14'h1;
            end
        end
        // Reset sources, only the latest one recorded
        rst_src = 5'h00;
        if (!external_reset_pin_s && s.por_done) begin
            rst_src[`PMRS_CAUSE_EXTERNAL_RESET_PIN] = 1'b1;
        end else if (s.por_done && wdt_fire) begin
            rst_src[`PMRS_CAUSE_WDT] = 1'b1;
        end else if (s.por_done && lvd_fire) begin
            rst_src[`PMRS_CAUSE_LVD] = 1'b1;
        end else if (s.por_done && software_reset_request_fire) begin
            rst_src[`PMRS_CAUSE_SOFTWARE_RESET_REQUEST] = 1'b1;
        end
        if (rst_src != 5'h00) begin
            // Same reinitialisation as power-on, but the watchdog lock and the timewheel count and divider survive
            next_s.mode = PMRS_ACTIVE;
            next_s.act_tpl = `PMRS_TPL_RST;
            next_s.alt_tpl = `PMRS_TPL_RST;
            next_s.software_reset_request_dis = 1'b0;
            next_s.wdt_load = `PMRS_WDT_LOAD_RST;
            next_s.wdt_cnt = `PMRS_WDT_LOAD_RST;
            next_s.tw_period = `PMRS_TW_PERIOD_RST;
            next_s.lvi_ctrl = 12'h000;
            next_s.lvi_flag = 3'h0;
            next_s.wake_cnt = 14'h0;
            next_s.rst_cnt = 4'(`PMRS_RST_CYC);
            next_s.cause = rst_src;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.mode <= PMRS_ACTIVE;
            s.act_tpl <= `PMRS_TPL_RST;
            s.alt_tpl <= `PMRS_TPL_RST;
            s.wdt_load <= `PMRS_WDT_LOAD_RST;
            s.wdt_cnt <= `PMRS_WDT_LOAD_RST;
            s.tw_period <= `PMRS_TW_PERIOD_RST;
            s.rst_cnt <= 4'(`PMRS_RST_CYC);
            s.cause <= 5'h01;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign reg_rdata = s.rdata;
    assign sys_rst_n = s.por_done && (s.rst_cnt == 4'h0);
    assign initial_power_on_reset_en = !s.por_done;
    assign power_mode = s.mode;
    assign cpu_pwr_en = (s.mode == PMRS_ACTIVE) ? s.act_tpl[0] :
                        (s.mode == PMRS_ALT) ? s.alt_tpl[0] : 1'b0;
    assign subsys_pwr_en = (s.mode == PMRS_ACTIVE) ? s.act_tpl :
                           (s.mode == PMRS_ALT) ? s.alt_tpl : 8'h00;
    assign io_hold = (s.mode == PMRS_HIB);
    assign timewheel_run = (s.mode != PMRS_HIB);
    assign mon_en = mon_on;
    assign digital_low_voltage_irq_trip_code = s.lvi_ctrl[`PMRS_LVIC_DCODE];
    assign analog_low_voltage_irq_trip_code = s.lvi_ctrl[`PMRS_LVIC_ACODE];
    assign digital_low_voltage_irq = s.lvi_flag[0];
    assign analog_low_voltage_irq = s.lvi_flag[1];
    assign analog_high_voltage_irq = s.lvi_flag[2];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    wake_to_active_a: assert property (
        s.mode == PMRS_WAKING && s.wake_cnt == 14'h0 && external_reset_pin_s |=> power_mode == PMRS_ACTIVE
        && cpu_pwr_en) else $error("wakeup did not reach active with processor on");
    sleep_wake_a: assert property (
        s.mode == PMRS_SLEEP && tw_hit && rst_src == 5'h00 |=> s.mode == PMRS_WAKING
        && s.wake_cnt == 14'(WAKE_CYCLES - 1)) else $error("sleep wakeup count wrong");
    hib_stays_a: assert property (
        s.mode == PMRS_HIB && external_reset_pin_s |=> s.mode == PMRS_HIB) else $error("left hibernate");
    external_reset_pin_holds_a: assert property (
        !external_reset_pin_s |=> !sys_rst_n ##1 !sys_rst_n) else $error("reset released while pin low");
    rst_pulse_a: assert property (
        $fell(sys_rst_n) |-> !sys_rst_n [*8]) else $error("reset pulse too short");
    software_reset_request_block_a: assert property (
        reg_wr && hit(reg_addr, `PMRS_OFF_RST_CTRL) && s.software_reset_request_dis && external_reset_pin_s && !wdt_fire
        && !lvd_fire |=> s.rst_cnt == $past(s.rst_cnt) - 4'h1 || s.rst_cnt == 4'h0)
        else $error("disabled software reset fired");
    wdt_lock_a: assert property (
        s.wdt_en |=> s.wdt_en) else $error("watchdog enable cleared");
    wdt_idle_a: assert property (
        s.mode == PMRS_SLEEP && rst_src == 5'h00 |=> $stable(s.wdt_cnt))
        else $error("watchdog counted in sleep");
    mon_off_a: assert property (
        s.mode inside {PMRS_SLEEP, PMRS_HIB, PMRS_WAKING} || !s.por_done |-> !mon_en)
        else $error("monitors active in low power");
    flag_sticky_a: assert property (
        s.lvi_flag[0] && !reg_wr && rst_src == 5'h00 |=> digital_low_voltage_irq)
        else $error("monitor flag dropped");
    cause_onehot_a: assert property (
        $onehot(s.cause)) else $error("reset cause not one flag");

    sleep_wake_c: cover property (s.mode == PMRS_WAKING ##1 s.mode == PMRS_ACTIVE);
    hib_exit_c: cover property (s.mode == PMRS_HIB ##1 !external_reset_pin_s);
    wdt_reset_c: cover property (rst_src[`PMRS_CAUSE_WDT]);
    software_reset_request_reset_c: cover property (rst_src[`PMRS_CAUSE_SOFTWARE_RESET_REQUEST]);
endmodule
`default_nettype wire

// ==== bench/pmrs_cpu_model.sv ====
// Processor model standing behind the system reset and power enables
`timescale 1ns/1ps
`default_nettype none
module pmrs_cpu_model (
    // Clock
    input wire logic core_clk,
    // Reset and power from the supervisor
    input wire logic sys_rst_n,
    input wire logic cpu_pwr_en,
    // Progress seen by the bench
    output logic [15:0] instr_cnt
);
    // Unpowered core retires nothing, so a stalled count shows a dead core
    always_ff @(posedge core_clk) begin
        if (!sys_rst_n) begin
            instr_cnt <= 16'h0000;
        end else if (cpu_pwr_en) begin
            instr_cnt <= instr_cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== bench/pmrs_supervisor_bench.sv ====
// Self-checking bench for the power mode and reset supervisor
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_defs.svh"
module pmrs_supervisor_bench;
    import pmrs_pkg::*;
    localparam int unsigned WAKE = 20;
    typedef struct packed {
        logic [7:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] e;
    } pmrs_row_t;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pin_n = 1'b1;
    logic sup_ok = 1'b0;
    logic [2:0] cmp = 3'b000;
    logic [31:0] reg_rdata;
    logic sys_rst_n, por_en, cpu_pwr_en, io_hold, tw_run, mon_en;
    logic [7:0] subsys_pwr_en;
    logic [3:0] dcode, acode;
    logic [2:0] irq;
    pmrs_mode_t power_mode;
    logic [15:0] instr_cnt, cnt0;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int wake_n;
    pmrs_row_t rows [14] = '{
        '{`PMRS_OFF_MODE, 1'b0, 32'h0, 32'h0},
        '{`PMRS_OFF_RST_CAUSE, 1'b0, 32'h0, 32'h1},
        '{`PMRS_OFF_ACT_TPL, 1'b0, 32'h0, 32'hff},
        '{`PMRS_OFF_ALT_TPL, 1'b0, 32'h0, 32'hff},
        '{`PMRS_OFF_WDT_LOAD, 1'b0, 32'h0, 32'h0f4240},
        '{`PMRS_OFF_TW_PERIOD, 1'b0, 32'h0, 32'h0},
        '{`PMRS_OFF_WDT_CTRL, 1'b0, 32'h0, 32'h0},
        '{`PMRS_OFF_RST_CTRL, 1'b0, 32'h0, 32'h0},
        '{`PMRS_OFF_LVI_STAT, 1'b0, 32'h0, 32'h0},
        '{`PMRS_OFF_LVI_CTRL, 1'b0, 32'h0, 32'h0},
        '{8'h40, 1'b1, 32'h5a, 32'h0},
        '{`PMRS_OFF_RST_CAUSE, 1'b1, 32'h1f, 32'h1},
        '{`PMRS_OFF_ALT_TPL, 1'b1, 32'h0e, 32'h0e},
        '{`PMRS_OFF_LVI_CTRL, 1'b1, 32'h703, 32'h703}
    };

    pmrs_supervisor #(.WAKE_CYCLES(WAKE)) dut_u (
        .core_clk(core_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .external_reset_pin_n(pin_n), .digital_supply_ok(sup_ok),
        .digital_low_voltage_cmp(cmp[0]), .analog_low_voltage_cmp(cmp[1]),
        .analog_high_voltage_cmp(cmp[2]), .sys_rst_n(sys_rst_n),
        .initial_power_on_reset_en(por_en), .cpu_pwr_en(cpu_pwr_en),
        .subsys_pwr_en(subsys_pwr_en), .io_hold(io_hold), .timewheel_run(tw_run),
        .power_mode(power_mode), .mon_en(mon_en), .digital_low_voltage_irq_trip_code(dcode),
        .analog_low_voltage_irq_trip_code(acode), .digital_low_voltage_irq(irq[0]),
        .analog_low_voltage_irq(irq[1]), .analog_high_voltage_irq(irq[2])
    );

    pmrs_cpu_model cpu_u (
        .core_clk(core_clk), .sys_rst_n(sys_rst_n), .cpu_pwr_en(cpu_pwr_en),
        .instr_cnt(instr_cnt)
    );

    always #5 core_clk = ~core_clk;

    // Hang guard: the whole sequence needs well under 5000 cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe, so look there
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e, "read data");
    endtask

    task automatic wait_rst(input logic lvl, input int max);
        int n;
        n = 0;
        while (sys_rst_n !== lvl && n < max) begin
            tick(1);
            n++;
        end
        chk({31'h0, sys_rst_n}, {31'h0, lvl}, "system reset");
    endtask

    task automatic wait_mode(input pmrs_mode_t m, input int max);
        int n;
        n = 0;
        while (power_mode !== m && n < max) begin
            tick(1);
            n++;
        end
        chk({29'h0, power_mode}, {29'h0, m}, "power mode");
    endtask

    task automatic pin_pulse(input int k);
        @(posedge core_clk);
        pin_n <= 1'b0;
        wait_rst(1'b0, 5);
        tick(k);
        chk({31'h0, sys_rst_n}, 32'h0, "held by pin");
        chk({16'h0, instr_cnt}, 32'h0, "core reinit");
        @(posedge core_clk);
        pin_n <= 1'b1;
        wait_rst(1'b1, 20);
    endtask

    initial begin
        // Supply still ramping: reset must outlast the release
        tick(12);
        arst_n <= 1'b1;
        tick(30);
        chk({30'h0, sys_rst_n, por_en}, 32'h1, "ramping supply");
        chk({31'h0, mon_en}, 32'h0, "monitors before por");
        @(posedge core_clk);
        sup_ok <= 1'b1;
        wait_rst(1'b1, 20);
        chk({30'h0, por_en, mon_en}, 32'h1, "por done");
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end
            rd(rows[i].a, rows[i].e);
        end
        wr(`PMRS_OFF_MODE, 32'h1);
        chk({23'h0, subsys_pwr_en, cpu_pwr_en}, {23'h0, 8'h0e, 1'b0}, "alternate");
        wr(`PMRS_OFF_MODE, 32'h0);
        wr(`PMRS_OFF_LVI_CTRL, 32'h7f3);
        chk({24'h0, acode, dcode}, 32'hc3, "trip codes");
        // Core switched off by its template, then a timed sleep
        wr(`PMRS_OFF_ACT_TPL, 32'hfe);
        wr(`PMRS_OFF_TW_PERIOD, 32'h2);
        wr(`PMRS_OFF_MODE, 32'h2);
        chk({29'h0, tw_run, mon_en, cpu_pwr_en}, 32'h4, "sleep outputs");
        @(posedge core_clk);
        cmp <= 3'b001;
        wait_mode(PMRS_WAKING, 400);
        chk({29'h0, irq}, 32'h0, "no irq asleep");
        wake_n = 0;
        while (power_mode === PMRS_WAKING && wake_n < 100) begin
            tick(1);
            wake_n++;
        end
        chk(wake_n, WAKE, "wake length");
        chk({28'h0, power_mode, cpu_pwr_en}, 32'h1, "awake");
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            cmp <= 3'b001 << i;
            tick(4);
            chk({29'h0, irq}, 32'h1 << i, "monitor irq");
            @(posedge core_clk);
            cmp <= 3'b000;
            tick(6);
            chk({29'h0, irq}, 32'h1 << i, "sticky irq");
            wr(`PMRS_OFF_LVI_STAT, 32'h1 << i);
            tick(1);
            chk({29'h0, irq}, 32'h0, "irq cleared");
        end
        wr(`PMRS_OFF_LVI_CTRL, 32'h0);
        @(posedge core_clk);
        cmp <= 3'b111;
        tick(6);
        chk({29'h0, irq}, 32'h0, "irq disabled");
        @(posedge core_clk);
        cmp <= 3'b000;
        // Hibernate ignores the timewheel and mode register writes
        wr(`PMRS_OFF_MODE, 32'h3);
        chk({30'h0, io_hold, tw_run}, 32'h2, "hibernate hold");
        tick(300);
        wr(`PMRS_OFF_MODE, 32'h0);
        chk({29'h0, power_mode}, {29'h0, PMRS_HIB}, "still hibernating");
        pin_pulse(30);
        chk({28'h0, power_mode, io_hold}, 32'h0, "active after pin");
        rd(`PMRS_OFF_RST_CAUSE, 32'h2);
        rd(`PMRS_OFF_ALT_TPL, 32'hff);
        wr(`PMRS_OFF_RST_CTRL, 32'h2);
        wr(`PMRS_OFF_RST_CTRL, 32'h3);
        tick(15);
        chk({31'h0, sys_rst_n}, 32'h1, "software reset blocked");
        wr(`PMRS_OFF_RST_CTRL, 32'h0);
        wr(`PMRS_OFF_RST_CTRL, 32'h1);
        wait_rst(1'b0, 5);
        wait_rst(1'b1, 20);
        rd(`PMRS_OFF_RST_CAUSE, 32'h4);
        // Watchdog kept alive, locked, then frozen in sleep
        wr(`PMRS_OFF_WDT_LOAD, 32'h40);
        wr(`PMRS_OFF_WDT_CTRL, 32'h1);
        repeat (4) begin
            tick(40);
            wr(`PMRS_OFF_WDT_CTRL, 32'h2);
        end
        chk({31'h0, sys_rst_n}, 32'h1, "kicked watchdog");
        rd(`PMRS_OFF_WDT_CTRL, 32'h1);
        wr(`PMRS_OFF_TW_PERIOD, 32'h0);
        wr(`PMRS_OFF_MODE, 32'h2);
        cnt0 = instr_cnt;
        tick(200);
        chk({31'h0, sys_rst_n}, 32'h1, "no watchdog asleep");
        chk({16'h0, instr_cnt}, {16'h0, cnt0}, "core halted");
        chk({29'h0, power_mode}, {29'h0, PMRS_SLEEP}, "period zero");
        pin_pulse(10);
        wr(`PMRS_OFF_WDT_LOAD, 32'h40);
        wr(`PMRS_OFF_WDT_CTRL, 32'h2);
        wait_rst(1'b0, 120);
        wait_rst(1'b1, 30);
        rd(`PMRS_OFF_RST_CAUSE, 32'h8);
        // Lowest digital trip with its reset enabled acts as low-voltage detect
        wr(`PMRS_OFF_LVI_CTRL, 32'h800);
        @(posedge core_clk);
        cmp <= 3'b001;
        wait_rst(1'b0, 8);
        @(posedge core_clk);
        cmp <= 3'b000;
        wait_rst(1'b1, 20);
        rd(`PMRS_OFF_RST_CAUSE, 32'h10);
        // Second power-on reset clears lock and cause
        @(posedge core_clk);
        arst_n <= 1'b0;
        tick(2);
        arst_n <= 1'b1;
        tick(9);
        chk({31'h0, sys_rst_n}, 32'h0, "minimum pulse");
        wait_rst(1'b1, 10);
        rd(`PMRS_OFF_WDT_CTRL, 32'h0);
        rd(`PMRS_OFF_RST_CAUSE, 32'h1);
        results();
    end
endmodule
`default_nettype wire
